// File: logic/cdb_pkg.sv
// cdb_pkg: constants, field layouts and types for one debounced counter channel.
// assumes a 20 MHz clk; the register port carries 16-bit data words.
`default_nettype none
package cdb_pkg;
    // clock and debounce timing
    localparam int          CLK_PERIOD_PS = 50000;
    localparam longint      DEB_MIN_NS    = 500;
    localparam longint      DEB_MAX_NS    = 25500000;
    localparam int          DEB_MIN_CYC   = int'((DEB_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int          DEB_MAX_CYC   = int'((DEB_MAX_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam int          DEB_STEPS     = 16;
    localparam int          DEB_W         = 20;

    // register indices on the plain port
    localparam logic [3:0]  REG_CTRL      = 4'h0;
    localparam logic [3:0]  REG_DEB       = 4'h1;
    localparam logic [3:0]  REG_CNT_LO    = 4'h2;
    localparam logic [3:0]  REG_CNT_HI    = 4'h3;
    localparam logic [3:0]  REG_SCAN_LO   = 4'h4;
    localparam logic [3:0]  REG_SCAN_HI   = 4'h5;
    localparam logic [15:0] CTRL_RESET    = 16'h0000;
    localparam logic [15:0] DEB_RESET     = 16'h0000;

    // counter modes and debounce modes
    localparam logic [1:0]  MODE_TOTAL    = 2'h0;
    localparam logic [1:0]  MODE_PERIOD   = 2'h1;
    localparam logic [1:0]  MODE_PULSE    = 2'h2;
    localparam logic [1:0]  MODE_TIMING   = 2'h3;
    localparam logic [1:0]  DEB_AFTER     = 2'h0;
    localparam logic [1:0]  DEB_BEFORE    = 2'h1;
    localparam logic [1:0]  DEB_BYPASS    = 2'h2;

    localparam logic [31:0] TOP32         = 32'hFFFFFFFF;
    localparam logic [15:0] TOP16         = 16'hFFFF;
    // divide and period-count ratios, selected by a 2-bit field
    localparam logic [9:0]  RATIO_1       = 10'h001;
    localparam logic [9:0]  RATIO_10      = 10'h00A;
    localparam logic [9:0]  RATIO_100     = 10'h064;
    localparam logic [9:0]  RATIO_1000    = 10'h3E8;

    // control register layout
    typedef struct packed {
        logic       map_latch;
        logic [1:0] other_sel;
        logic       gate_en;
        logic [1:0] gate_sel;
        logic [1:0] periods;
        logic [1:0] tick_sel;
        logic       type32;
        logic       sat;
        logic       clr_on_rd;
        logic [1:0] mode;
    } cdb_ctrl_type;

    // debounce register layout
    typedef struct packed {
        logic       invert;
        logic [1:0] dmode;
        logic [3:0] dtime;
    } cdb_deb_type;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } cdb_req_type;

    typedef struct packed {
        logic [31:0] lo_hi;
        logic [15:0] lo;
        logic [15:0] hi;
    } cdb_scan_type;
endpackage
`default_nettype wire

// File: logic/cdb_channel.sv
// cdb_channel: one counter input channel, inversion, debounce and a four-mode counter.
// assumes ch_pin is asynchronous; map_in, scan strobes and the register port share clk.
//
// Contract
// - reading count low snapshots all 32 bits; high read returns that snapshot
// - totalize adds one per accepted conditioned rising edge into 32 bits
// - low half readable by the scan every clock, well above 8 MHz
// - full count takes two slots, one per half, so half the rate
// - count keeps accumulating; cleared when a new scan starts or by a clear on read
// - without saturation the count wraps at the 32 bit boundary for either type
// - clear on read returns current count then restarts from zero
// - saturating mode holds at FFFF or FFFFFFFF by counter type
// - counter type changes only the saturation point
// - period mode times 1, 10, 100 or 1000 input periods
// - measurements count ticks of clock divided by 1, 10, 100 or 1000
// - period measurement may be gated by another selected channel
// - pulse width counts ticks while input is high, optionally gated
// - timing counts ticks from own edge to next edge on other channel
// - sixteen debounce times from 500 ns to 25.5 ms
// - optional inversion before debounce picks rising or falling sensitivity
// - bypass passes the inverted input straight on, ignoring debounce time
// - stable-first mode changes output after input held new level full time
// - stable-first mode rejects disturbances that never hold for the time
// - edge-first mode follows an edge at once, then blocks until stable
// - scan start resets the counter to zero
// - scan latches count each scan, or a mapped channel edge latches it
//
// The register addresses and the strobed register port were chosen for this implementation.
`default_nettype none
module cdb_channel #(
    parameter int deb_max_cycles = cdb_pkg::DEB_MAX_CYC
) (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic                  ch_pin,
    input  wire logic [3:0]            map_in,
    input  wire logic                  scan_start,
    input  wire logic                  scan_latch,
    input  wire cdb_pkg::cdb_req_type  req,
    output logic      [15:0]           rdata,
    output cdb_pkg::cdb_scan_type      scan_out,
    output logic                       ch_out
);
    typedef struct packed {
        logic [2:0]                     sync;
        logic                           lvl;
        logic                           cond_prev;
        logic                           dout;
        logic [cdb_pkg::DEB_W-1:0]      stab;
        logic                           s_prev;
        logic [3:0]                     map_prev;
        logic [9:0]                     pre;
        logic [9:0]                     per_n;
        logic                           armed;
        logic [31:0]                    cnt;
        logic [31:0]                    acc;
        logic [31:0]                    snap;
        logic [31:0]                    scan_val;
        logic [15:0]                    rdata;
        cdb_pkg::cdb_ctrl_type          ctrl;
        cdb_pkg::cdb_deb_type           deb;
    } cdb_state_type;

    cdb_state_type st;
    cdb_state_type nx;

    // reset image kept as one constant so the async branch loads constants only
    localparam cdb_state_type ST_RESET = '{
        ctrl:    cdb_pkg::cdb_ctrl_type'(cdb_pkg::CTRL_RESET[14:0]),
        deb:     cdb_pkg::cdb_deb_type'(cdb_pkg::DEB_RESET[6:0]),
        default: '0
    };

    logic [cdb_pkg::DEB_W-1:0] deb_tab [cdb_pkg::DEB_STEPS];

    // debounce times spread evenly from the shortest to the longest setting
    for (genvar i = 0; i < cdb_pkg::DEB_STEPS; i++) begin : g_deb
        localparam longint SPAN = longint'(deb_max_cycles - cdb_pkg::DEB_MIN_CYC);
        localparam longint CYC  = cdb_pkg::DEB_MIN_CYC + SPAN * i / (cdb_pkg::DEB_STEPS - 1);
        assign deb_tab[i] = CYC[cdb_pkg::DEB_W-1:0];
    end

    function automatic logic [31:0] bump(input logic [31:0] v, input logic sat,
                                         input logic t32);
        logic top;
        top = t32 ? (v == cdb_pkg::TOP32) : (v[15:0] == cdb_pkg::TOP16);
        // type only matters while saturating
        if (sat && top) begin
            bump = v;
        end else begin
            bump = v + 32'h1;
        end
    endfunction

    function automatic logic [9:0] ratio(input logic [1:0] sel);
        case (sel)
            2'h0:    ratio = cdb_pkg::RATIO_1;
            2'h1:    ratio = cdb_pkg::RATIO_10;
            2'h2:    ratio = cdb_pkg::RATIO_100;
            default: ratio = cdb_pkg::RATIO_1000;
        endcase
    endfunction

    logic                      cond;
    logic [cdb_pkg::DEB_W-1:0] deb_n;
    logic [cdb_pkg::DEB_W-1:0] stab_n;
    logic                      rise;
    logic                      fall;
    logic                      tick;
    logic                      gate_ok;
    logic                      other_rise;
    logic                      map_rise;
    logic                      rd_lo;
    logic                      rd_clr;
    logic [31:0]               cnt_base;

    always_comb begin
        nx = st;
        // three-stage synchroniser; a level counts once stages two and three agree
        nx.sync = {st.sync[1:0], ch_pin};
        if (st.sync[2] == st.sync[1]) begin
            nx.lvl = st.sync[2];
        end
        cond = st.lvl ^ st.deb.invert;
        nx.cond_prev = cond;

        // stability timer, restarted by any change of the conditioned input
        deb_n = deb_tab[st.deb.dtime];
        if (cond != st.cond_prev) begin
            stab_n = '0;
        end else if (st.stab < deb_n) begin
            stab_n = st.stab + 1'b1;
        end else begin
            stab_n = st.stab;
        end
        nx.stab = stab_n;

        case (st.deb.dmode)
            cdb_pkg::DEB_AFTER: begin
                // short bursts never reach deb_n, so they never pass
                if (cond == st.cond_prev && stab_n >= deb_n) begin
                    nx.dout = cond;
                end
            end
            cdb_pkg::DEB_BEFORE: begin
                // an edge after a quiet spell goes through at once
                if (cond != st.cond_prev && st.stab >= deb_n) begin
                    nx.dout = cond;
                end else if (stab_n >= deb_n) begin
                    nx.dout = cond;
                end
            end
            default: begin
                nx.dout = cond;
            end
        endcase

        // counter module, fed by the registered debounce output
        nx.s_prev   = st.dout;
        nx.map_prev = map_in;
        rise        = st.dout & ~st.s_prev;
        fall        = ~st.dout & st.s_prev;
        other_rise  = map_in[st.ctrl.other_sel] & ~st.map_prev[st.ctrl.other_sel];
        map_rise    = map_in[st.ctrl.gate_sel] & ~st.map_prev[st.ctrl.gate_sel];
        gate_ok     = ~st.ctrl.gate_en | map_in[st.ctrl.gate_sel];

        // tick prescaler
        if (st.pre >= ratio(st.ctrl.tick_sel) - 10'h1) begin
            nx.pre = '0;
            tick   = 1'b1;
        end else begin
            nx.pre = st.pre + 10'h1;
            tick   = 1'b0;
        end

        rd_lo  = req.rd && req.addr == cdb_pkg::REG_CNT_LO;
        rd_clr = rd_lo && st.ctrl.clr_on_rd;
        // a read clear drops the old value but keeps this cycle's event
        cnt_base = rd_clr ? 32'h0 : st.cnt;

        case (st.ctrl.mode)
            cdb_pkg::MODE_TOTAL: begin
                nx.cnt = rise ? bump(cnt_base, st.ctrl.sat, st.ctrl.type32) : cnt_base;
            end
            cdb_pkg::MODE_PERIOD: begin
                nx.cnt = cnt_base;
                if (tick && st.armed && gate_ok) begin
                    nx.acc = bump(st.acc, st.ctrl.sat, st.ctrl.type32);
                end
                if (rise) begin
                    if (!st.armed) begin
                        nx.armed = 1'b1;
                        nx.acc   = '0;
                        nx.per_n = '0;
                    end else if (st.per_n + 10'h1 >= ratio(st.ctrl.periods)) begin
                        nx.cnt   = st.acc;
                        nx.acc   = '0;
                        nx.per_n = '0;
                    end else begin
                        nx.per_n = st.per_n + 10'h1;
                    end
                end
            end
            cdb_pkg::MODE_PULSE: begin
                nx.cnt = cnt_base;
                if (rise) begin
                    nx.acc = '0;
                end else if (st.dout && tick && gate_ok) begin
                    nx.acc = bump(st.acc, st.ctrl.sat, st.ctrl.type32);
                end
                if (fall) begin
                    nx.cnt = st.acc;
                end
            end
            cdb_pkg::MODE_TIMING: begin
                nx.cnt = cnt_base;
                if (st.armed && other_rise) begin
                    nx.cnt   = st.acc;
                    nx.armed = 1'b0;
                end else if (rise) begin
                    nx.armed = 1'b1;
                    nx.acc   = '0;
                end else if (st.armed && tick) begin
                    nx.acc = bump(st.acc, st.ctrl.sat, st.ctrl.type32);
                end
            end
            default: begin
                nx.cnt = cnt_base;
            end
        endcase

        // a new scan clears count, accumulator, arming and period count and wins over counting
        if (scan_start) begin
            nx.cnt   = '0;
            nx.acc   = '0;
            nx.armed = 1'b0;
            nx.per_n = '0;
        end

        // per-scan latch, or the mapped channel's edge instead
        if (st.ctrl.map_latch ? map_rise : scan_latch) begin
            nx.scan_val = st.cnt;
        end

        // register port
        nx.rdata = '0;
        if (req.wr) begin
            case (req.addr)
                cdb_pkg::REG_CTRL: nx.ctrl = cdb_pkg::cdb_ctrl_type'(req.wdata[14:0]);
                cdb_pkg::REG_DEB:  nx.deb  = cdb_pkg::cdb_deb_type'(req.wdata[6:0]);
                default:           nx.ctrl = st.ctrl;
            endcase
        end
        if (req.rd) begin
            case (req.addr)
                cdb_pkg::REG_CTRL:    nx.rdata = {1'b0, st.ctrl};
                cdb_pkg::REG_DEB:     nx.rdata = {9'h0, st.deb};
                cdb_pkg::REG_CNT_LO: begin
                    nx.snap  = st.cnt;
                    nx.rdata = st.cnt[15:0];
                end
                cdb_pkg::REG_CNT_HI:  nx.rdata = st.snap[31:16];
                cdb_pkg::REG_SCAN_LO: nx.rdata = st.scan_val[15:0];
                cdb_pkg::REG_SCAN_HI: nx.rdata = st.scan_val[31:16];
                default:              nx.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st <= ST_RESET;
        end else begin
            st <= nx;
        end
    end

    // halves are separate outputs of the one scan_val register so the sequencer can take one per slot
    assign rdata          = st.rdata;
    assign scan_out.lo_hi = st.scan_val;
    assign scan_out.lo    = st.scan_val[15:0];
    assign scan_out.hi    = st.scan_val[31:16];
    assign ch_out         = st.dout;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_snapshot;
        rd_lo ##1 (req.rd && req.addr == cdb_pkg::REG_CNT_HI) |=> rdata == $past(st.cnt[31:16], 2);
    endproperty
    a_snapshot: assert property (p_snapshot) else $error("high half not from snapshot");

    property p_total_inc;
        (st.ctrl.mode == cdb_pkg::MODE_TOTAL && rise && !scan_start && !rd_clr
         && !st.ctrl.sat) |=> st.cnt == $past(st.cnt) + 32'h1;
    endproperty
    a_total_inc: assert property (p_total_inc) else $error("totalize missed an event");

    property p_scan_clear;
        scan_start |=> st.cnt == 32'h0;
    endproperty
    a_scan_clear: assert property (p_scan_clear) else $error("scan start did not clear");

    property p_hold;
        (st.ctrl.mode == cdb_pkg::MODE_TOTAL && !rise && !scan_start && !rd_clr)
        |=> $stable(st.cnt);
    endproperty
    a_hold: assert property (p_hold) else $error("count changed without event");

    property p_clear_read;
        (rd_clr && !scan_start && st.ctrl.mode == cdb_pkg::MODE_TOTAL)
        |=> rdata == $past(st.cnt[15:0]) && st.cnt <= 32'h1;
    endproperty
    a_clear_read: assert property (p_clear_read) else $error("clear on read failed");

    property p_sat;
        (st.ctrl.mode == cdb_pkg::MODE_TOTAL && st.ctrl.sat && st.ctrl.type32
         && st.cnt == cdb_pkg::TOP32 && !scan_start && !rd_clr) |=> st.cnt == cdb_pkg::TOP32;
    endproperty
    a_sat: assert property (p_sat) else $error("saturated count moved");

    property p_roll;
        (st.ctrl.mode == cdb_pkg::MODE_TOTAL && !st.ctrl.sat && rise
         && st.cnt == cdb_pkg::TOP32 && !scan_start && !rd_clr) |=> st.cnt == 32'h0;
    endproperty
    a_roll: assert property (p_roll) else $error("count did not roll over");

    property p_bypass;
        (st.deb.dmode == cdb_pkg::DEB_BYPASS) |=> st.dout == $past(cond);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass did not follow input");

    property p_after_reject;
        (st.deb.dmode == cdb_pkg::DEB_AFTER && cond != st.cond_prev) |=> $stable(st.dout);
    endproperty
    a_after_reject: assert property (p_after_reject) else $error("unstable edge passed");
endmodule
`default_nettype wire

// File: verification/cdb_pulse_src.sv
// cdb_pulse_src: pulse source standing in for a switch or pulse generator on ch_pin.
// assumes the bench calls its tasks; the pin changes just after a rising clk edge.
`default_nettype none
module cdb_pulse_src (
    input  wire logic clk,
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial pin = 1'b0;

    // one high phase then one low phase, both in whole clk cycles
    task automatic pulse(input int hi, input int lo);
        @(posedge clk);
        pin <= 1'b1;
        repeat (hi) @(posedge clk);
        pin <= 1'b0;
        repeat (lo) @(posedge clk);
    endtask

    // set a level now and let one edge pass
    task automatic drive(input logic lvl);
        pin <= lvl;
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// tb_top: self-checking bench for one debounced counter channel.
// assumes a 20 MHz clk and a shortened debounce range of 40 cycles.
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                 clk;
    logic                 arst_n;
    logic                 ch_pin;
    logic [3:0]           map_in;
    logic                 scan_start;
    logic                 scan_latch;
    cdb_pkg::cdb_req_type req;
    logic [15:0]          rdata;
    cdb_pkg::cdb_scan_type scan_out;
    logic                 ch_out;
    cdb_pkg::cdb_ctrl_type c;
    cdb_pkg::cdb_deb_type  d;
    logic [15:0]          v;
    int                   failures;
    int                   cmp_count;
    int                   cycles;
    int                   expv;

    cdb_channel #(.deb_max_cycles(40)) dut (
        .clk        (clk),
        .arst_n     (arst_n),
        .ch_pin     (ch_pin),
        .map_in     (map_in),
        .scan_start (scan_start),
        .scan_latch (scan_latch),
        .req        (req),
        .rdata      (rdata),
        .scan_out   (scan_out),
        .ch_out     (ch_out)
    );

    cdb_pulse_src src (
        .clk (clk),
        .pin (ch_pin)
    );

    initial clk = 1'b0;
    always #25 clk = ~clk;

    task automatic end_of_test();
        if (failures == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // long sat pulse dominates the run; ceiling leaves margin above it
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            failures = failures + 1;
            end_of_test();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // tick counts may differ by a cycle or two of pipeline
    task automatic chk_near(input string name, input logic [15:0] seen, input int exp);
        int diff;
        diff = int'(seen) - exp;
        chk(name, (diff <= 2 && diff >= -2) ? 32'(exp) : 32'(seen), 32'(exp));
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] data);
        @(posedge clk);
        req <= '{addr: a, wdata: data, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] data);
        @(posedge clk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 data = rdata;
    endtask

    task automatic strobe(input bit latch);
        @(posedge clk);
        if (latch) scan_latch <= 1'b1;
        else scan_start <= 1'b1;
        @(posedge clk);
        scan_latch <= 1'b0;
        scan_start <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic pulses(input int n);
        repeat (n) src.pulse(2, 4);
        repeat (8) @(posedge clk);
    endtask

    initial begin
        failures = 0;
        cmp_count = 0;
        cycles = 0;
        arst_n = 1'b0;
        map_in = 4'h0;
        scan_start = 1'b0;
        scan_latch = 1'b0;
        req = '0;
        c = '0;
        d = '0;
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd(cdb_pkg::REG_CTRL, v);
        chk("ctrl reset", 32'(v), 32'(cdb_pkg::CTRL_RESET));
        rd(cdb_pkg::REG_DEB, v);
        chk("deb reset", 32'(v), 32'(cdb_pkg::DEB_RESET));
        rd(4'hF, v);
        chk("unmapped read", 32'(v), 32'h00000000);
        // stable-first, shortest time: 10 cycles
        src.pulse(5, 40);
        rd(cdb_pkg::REG_CNT_LO, v);
        chk("glitch count", 32'(v), 32'h00000000);
        src.pulse(20, 40);
        rd(cdb_pkg::REG_CNT_LO, v);
        chk("stable count", 32'(v), 32'h00000001);
        rd(cdb_pkg::REG_CNT_HI, v);
        chk("stable count hi", 32'(v), 32'h00000000);
        d.dmode = cdb_pkg::DEB_BEFORE;
        wr(cdb_pkg::REG_DEB, 16'(d));
        repeat (20) @(posedge clk);
        @(posedge clk);
        src.drive(1'b1);
        repeat (3) @(posedge clk);
        src.drive(1'b0);
        repeat (3) @(posedge clk);
        #1 chk("edge first out", 32'(ch_out), 32'h00000001);
        repeat (40) @(posedge clk);
        rd(cdb_pkg::REG_CNT_LO, v);
        chk("edge first count", 32'(v), 32'h00000002);
        d = '{invert: 1'b0, dmode: cdb_pkg::DEB_BYPASS, dtime: 4'hF};
        wr(cdb_pkg::REG_DEB, 16'(d));
        strobe(1'b0);
        rd(cdb_pkg::REG_CNT_LO, v);
        chk("scan clear", 32'(v), 32'h00000000);
        pulses(4);
        strobe(1'b1);
        chk("scan out lo", 32'(scan_out.lo), 32'h00000004);
        chk("scan out full", scan_out.lo_hi, 32'h00000004);
        chk("scan out hi", 32'(scan_out.hi), 32'h00000000);
        pulses(1);
        rd(cdb_pkg::REG_SCAN_LO, v);
        chk("scan lo reg", 32'(v), 32'h00000004);
        rd(cdb_pkg::REG_CNT_LO, v);
        chk("accumulate", 32'(v), 32'h00000005);
        c.clr_on_rd = 1'b1;
        wr(cdb_pkg::REG_CTRL, 16'(c));
        pulses(3);
        rd(cdb_pkg::REG_CNT_LO, v);
        chk("clear on read", 32'(v), 32'h00000008);
        rd(cdb_pkg::REG_CNT_LO, v);
        chk("after clear", 32'(v), 32'h00000000);
        d.invert = 1'b1;
        wr(cdb_pkg::REG_DEB, 16'(d));
        repeat (8) @(posedge clk);
        #1 chk("inverted idle", 32'(ch_out), 32'h00000001);
        rd(cdb_pkg::REG_CNT_LO, v);
        pulses(1);
        rd(cdb_pkg::REG_CNT_LO, v);
        chk("falling edge count", 32'(v), 32'h00000001);
        d.invert = 1'b0;
        wr(cdb_pkg::REG_DEB, 16'(d));
        c = '0;
        c.mode = cdb_pkg::MODE_PULSE;
        for (int i = 0; i < 4; i++) begin
            c.tick_sel = 2'(i);
            wr(cdb_pkg::REG_CTRL, 16'(c));
            strobe(1'b0);
            src.pulse((i == 3) ? 2000 : 200, 10);
            rd(cdb_pkg::REG_CNT_LO, v);
            expv = (i == 0) ? 200 : (i == 1) ? 20 : 2;
            chk_near("pulse width ticks", v, expv);
        end
        c = '0;
        c.mode = cdb_pkg::MODE_TIMING;
        wr(cdb_pkg::REG_CTRL, 16'(c));
        strobe(1'b0);
        src.pulse(5, 30);
        map_in <= 4'h1;
        repeat (3) @(posedge clk);
        map_in <= 4'h0;
        rd(cdb_pkg::REG_CNT_LO, v);
        chk_near("timing ticks", v, 30);
        c = '0;
        c.mode = cdb_pkg::MODE_PERIOD;
        c.gate_en = 1'b1;
        c.gate_sel = 2'h1;
        wr(cdb_pkg::REG_CTRL, 16'(c));
        strobe(1'b0);
        repeat (3) src.pulse(10, 10);
        rd(cdb_pkg::REG_CNT_LO, v);
        chk("gated period", 32'(v), 32'h00000000);
        c = '0;
        c.map_latch = 1'b1;
        c.gate_sel = 2'h2;
        wr(cdb_pkg::REG_CTRL, 16'(c));
        strobe(1'b0);
        pulses(3);
        map_in <= 4'h4;
        repeat (3) @(posedge clk);
        map_in <= 4'h0;
        chk("mapped latch", scan_out.lo_hi, 32'h00000003);
        c = '0;
        c.mode = cdb_pkg::MODE_PERIOD;
        c.tick_sel = 2'h0;
        wr(cdb_pkg::REG_CTRL, 16'(c));
        strobe(1'b0);
        repeat (3) src.pulse(10, 10);
        rd(cdb_pkg::REG_CNT_LO, v);
        chk_near("one period", v, 20);
        c.mode = cdb_pkg::MODE_PULSE;
        c.sat = 1'b1;
        wr(cdb_pkg::REG_CTRL, 16'(c));
        strobe(1'b0);
        src.pulse(65600, 10);
        rd(cdb_pkg::REG_CNT_LO, v);
        chk("sat lo", 32'(v), 32'(cdb_pkg::TOP16));
        rd(cdb_pkg::REG_CNT_HI, v);
        chk("sat hi", 32'(v), 32'h00000000);
        end_of_test();
    end
endmodule
`default_nettype wire
